// ==== hw/brf_core.sv ====
// Banked register file RAM: 512 bytes of data memory with sixteen register banks overlaid.
// Assumes one CPU request per cycle on req_in and a fetch address on every instruction fetch.
`timescale 1ns/100ps
`default_nettype none

module brf_core
   import brf_pkg::*;
(
   input  wire logic             clk_in,          // CPU clock, 25 MHz.
   input  wire logic             arst_n_in,       // Asynchronous reset, active low.
   input  wire brf_req_t         req_in,          // CPU request, one per cycle.
   input  wire logic             fetch_valid_in,  // Instruction fetch strobe.
   input  wire logic [15:0]      fetch_addr_in,   // Program counter of the fetch.
   input  wire logic             rst_pin_in,      // Level read back from the reset pin.
   output logic                  rst_pin_out,     // Reset pin drive value, always low.
   output logic                  rst_pin_oe_out,  // High while the pin is pulled low.
   output brf_resp_t             resp_out,        // Registered answer to the request.
   output logic [BANK_W-1:0]     bank_out,        // Current bank selector.
   output logic                  bus_error_out,   // One-cycle bus error pulse.
   output logic                  trap_reset_out   // Address-trap reset in progress.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.
   // The data space is sixteen bits wide, but only 0040 to 023F hold storage here.
   // Addresses below 0040 belong to special function registers outside this block,
   // and everything above 023F is program space, so both answer with an error.

   // True when a data address lands inside the RAM.
   function automatic logic in_ram(input logic [15:0] a);
      in_ram = (a >= RAM_BASE) && (a <= RAM_LAST);
   endfunction

   // Storage index of a RAM address; the bank region maps straight through.
   // Addresses outside the RAM wrap into it, so writes are gated with in_ram; the BRF_CMD_MEM_OP answer data is not.
   function automatic logic [IDX_W-1:0] ram_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - RAM_BASE;
      ram_idx = d[IDX_W-1:0];
   endfunction

   // Storage index of one register of one bank: base plus eight per bank.
   // The bank number lands in index bits 6 to 3, so even banks take the low half
   // of each sixteen-byte row and odd banks the high half, with no adder in the path.
   function automatic logic [IDX_W-1:0] reg_idx(input logic [BANK_W-1:0] b, input logic [2:0] r);
      reg_idx = {2'b00, b, r};
   endfunction

   // Result of a memory-to-memory operation, destination first.
   // Unknown operation codes fall back to a plain move, so a stray code never
   // leaves the destination byte undefined.
   function automatic logic [7:0] alu(input brf_aluop_t op, input logic [7:0] d, input logic [7:0] s);
      case (op)
         BRF_OP_MOVE: alu = s;
         BRF_OP_ADD:  alu = d + s;
         BRF_OP_SUB:  alu = d - s;
         BRF_OP_AND:  alu = d & s;
         BRF_OP_OR:   alu = d | s;
         BRF_OP_XOR:  alu = d ^ s;
         default:     alu = s;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   // The RAM is a flat array of flip-flops indexed from 0040; registers, pairs,
   // the stack and user bytes are all views of it, so no copy can ever go stale.

   logic [7:0]        mem_r   [0:RAM_BYTES-1];
   logic [7:0]        mem_nxt [0:RAM_BYTES-1];
   logic [BANK_W-1:0] bank_r, bank_nxt;
   brf_resp_t         resp_r, resp_nxt;
   logic [TRAP_CNT_W-1:0] trap_cnt_r, trap_cnt_nxt;
   logic              trap_r, trap_nxt;
   logic              berr_r, berr_nxt;

   // Operand views of the current bank.
   // They are read combinationally from the storage, so a pair written at one edge
   // already steers the address of a request taken at the next edge.
   logic [15:0] pri_ptr;
   logic [15:0] sec_ptr;
   logic [7:0]  offset;
   logic [15:0] ea;
   logic [15:0] ptr_upd;
   logic        ptr_wr;

   ////////////////////////////////////////////////////////////////////////////////
   // Effective address. Pairs are read straight out of the RAM bytes of the bank.
   // The index displacement is sign-extended, so a pointer can reach back as well as ahead.
   // Base mode adds the offset register unsigned, which only ever moves forward.
   // Sums wrap at sixteen bits; a wrap below zero falls outside the RAM and errors, a wrap past FFFF can land inside it.

   always_comb begin
      pri_ptr = {mem_r[reg_idx(bank_r, {PAIR_PRI, 1'b1})], mem_r[reg_idx(bank_r, {PAIR_PRI, 1'b0})]};
      sec_ptr = {mem_r[reg_idx(bank_r, {PAIR_SEC, 1'b1})], mem_r[reg_idx(bank_r, {PAIR_SEC, 1'b0})]};
      offset  = mem_r[reg_idx(bank_r, REG_OFFSET)];
      ptr_upd = pri_ptr;
      ptr_wr  = 1'b0;
      case (req_in.mode)
         BRF_MODE_DIRECT:  ea = req_in.addr;
         BRF_MODE_SHORT:   ea = {8'h00, req_in.addr[7:0]};
         BRF_MODE_PTR_PRI: ea = pri_ptr;
         BRF_MODE_PTR_SEC: ea = sec_ptr;
         BRF_MODE_INDEX:   ea = pri_ptr + {{8{req_in.disp[7]}}, req_in.disp};
         BRF_MODE_BASE:    ea = pri_ptr + {8'h00, offset};
         BRF_MODE_POST_INC: begin
            ea      = pri_ptr;
            ptr_upd = pri_ptr + 16'h0001;
            ptr_wr  = 1'b1;
         end
         BRF_MODE_PRE_DEC: begin
            ptr_upd = pri_ptr - 16'h0001;
            ea      = ptr_upd;
            ptr_wr  = 1'b1;
         end
         default:          ea = req_in.addr;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request execution. Storage is one array, so register and memory views never disagree.
   // Register, pair and bank commands cannot miss the RAM, so only memory and interrupt stack
   // commands report an error, and an erroring write skips its target byte, though post-increment and pre-decrement still step the pointer.

   always_comb begin
      logic [IDX_W-1:0] di;
      logic [IDX_W-1:0] si;
      logic [IDX_W-1:0] pi;
      logic [7:0]       res;
      logic             ok;
      logic             mem_cmd;
      di       = ram_idx(ea);
      si       = ram_idx(sec_ptr);
      pi       = reg_idx(bank_r, {req_in.sel[1:0], 1'b0});
      res      = alu(req_in.aluop, mem_r[ram_idx(ea)], mem_r[ram_idx(sec_ptr)]);
      ok       = in_ram(ea);
      mem_cmd  = 1'b0;
      mem_nxt  = mem_r;
      bank_nxt = bank_r;
      resp_nxt = '0;
      resp_nxt.ea = ea;
      // A device in trap reset, or with its pin held low, takes no requests.
      if (!trap_r && rst_pin_in) begin
         resp_nxt.valid = (req_in.cmd != BRF_CMD_NONE);
         case (req_in.cmd)
            // Plain memory access; out-of-range reads answer zero with the error bit.
            BRF_CMD_MEM_RD: begin
               mem_cmd = 1'b1;
               resp_nxt.err  = !ok;
               resp_nxt.data = ok ? {8'h00, mem_r[di]} : 16'h0000;
            end
            BRF_CMD_MEM_WR: begin
               mem_cmd = 1'b1;
               resp_nxt.err = !ok;
               if (ok) begin
                  mem_nxt[di] = req_in.wdata[7:0];
               end
            end
            // Single registers of the current bank, selected by the three-bit field.
            BRF_CMD_REG_RD: begin
               resp_nxt.data = {8'h00, mem_r[reg_idx(bank_r, req_in.sel)]};
            end
            // A register write lands at the edge that takes it.
            BRF_CMD_REG_WR: begin
               mem_nxt[reg_idx(bank_r, req_in.sel)] = req_in.wdata[7:0];
            end
            // Pairs are little-endian: the even byte is low and the odd byte high.
            BRF_CMD_PAIR_RD: begin
               resp_nxt.data = {mem_r[pi + 9'h001], mem_r[pi]};
            end
            // Both bytes of a pair change at one edge, so no half-written pair is seen.
            BRF_CMD_PAIR_WR: begin
               mem_nxt[pi]          = req_in.wdata[7:0];
               mem_nxt[pi + 9'h001] = req_in.wdata[15:8];
            end
            BRF_CMD_MEM_OP: begin
               // Source at the secondary pointer, destination at the addressed byte.
               mem_cmd = 1'b1;
               resp_nxt.err  = !(ok && in_ram(sec_ptr));
               resp_nxt.data = {8'h00, res};
               if (ok && in_ram(sec_ptr)) begin
                  mem_nxt[di] = alu(req_in.aluop, mem_r[di], mem_r[si]);
               end
            end
            // The selector changes at this edge; the next request already sees the new bank.
            BRF_CMD_BANK_WR: begin
               bank_nxt = req_in.wdata[BANK_W-1:0];
            end
            BRF_CMD_IRQ_ENTRY: begin
               // The stack address arrives in addr; the flags come from the core.
               resp_nxt.err = !in_ram(req_in.addr);
               if (in_ram(req_in.addr)) begin
                  mem_nxt[ram_idx(req_in.addr)] = {req_in.flags, bank_r};
               end
            end
            // Only the selector is restored; the flags live outside this block.
            BRF_CMD_IRQ_RETURN: begin
               resp_nxt.err = !in_ram(req_in.addr);
               if (in_ram(req_in.addr)) begin
                  resp_nxt.data = {8'h00, mem_r[ram_idx(req_in.addr)]};
                  bank_nxt = mem_r[ram_idx(req_in.addr)][PSW_BANK_LSB +: BANK_W];
               end
            end
            default: begin
               resp_nxt.valid = 1'b0;
            end
         endcase
         // The pointer update lands after the data write, so a pointer aimed at itself still steps.
         // Register-only commands never step the pointer, whatever mode field they carry.
         if (mem_cmd && ptr_wr) begin
            mem_nxt[reg_idx(bank_r, {PAIR_PRI, 1'b0})] = ptr_upd[7:0];
            mem_nxt[reg_idx(bank_r, {PAIR_PRI, 1'b1})] = ptr_upd[15:8];
         end
      end
      // A trap or a low reset pin puts the selector back to bank zero.
      // Using the next trap value clears the bank in the very cycle the trap starts,
      // so the first cycle of the reset already shows bank zero.
      if (trap_nxt || !rst_pin_in) begin
         bank_nxt = BANK_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address trap: a fetch from data memory stops execution and holds reset a fixed time.
   // Fetches seen while the trap already runs are ignored, so a stuck program counter
   // cannot stretch the reset pulse. The counter restarts from zero on every trap,
   // which keeps the pulse length fixed whatever state the previous trap left.

   always_comb begin
      berr_nxt     = 1'b0;
      trap_nxt     = trap_r;
      trap_cnt_nxt = trap_cnt_r;
      if (trap_r) begin
         if (trap_cnt_r == TRAP_CNT_W'(TRAP_HOLD_CYC - 1)) begin
            trap_nxt     = 1'b0;
            trap_cnt_nxt = '0;
         end else begin
            trap_cnt_nxt = trap_cnt_r + TRAP_CNT_W'(1);
         end
      end else if (fetch_valid_in && in_ram(fetch_addr_in)) begin
         berr_nxt     = 1'b1;
         trap_nxt     = 1'b1;
         trap_cnt_nxt = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers. RAM contents are left uninitialised, as storage is unknown at power-up.
   // Leaving the array out of the reset saves a wide reset tree; software must
   // initialise it, sparing the bank that it is running in.

   always_ff @(posedge clk_in) begin
      mem_r <= mem_nxt;
   end

   // Control state resets; the selector starts at bank zero.
   // The answer register resets too, so no stale valid pulse follows a reset.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bank_r     <= BANK_RESET;
         resp_r     <= '0;
         trap_r     <= 1'b0;
         trap_cnt_r <= '0;
         berr_r     <= 1'b0;
      end else begin
         bank_r     <= bank_nxt;
         resp_r     <= resp_nxt;
         trap_r     <= trap_nxt;
         trap_cnt_r <= trap_cnt_nxt;
         berr_r     <= berr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs. The reset pin is open drain: only ever pulled low.
   // The enable follows the trap register directly, so the pin is released in the
   // same cycle that the trap ends and the board pull-up takes it high again.

   assign rst_pin_out    = 1'b0;
   assign rst_pin_oe_out = trap_r;
   assign resp_out       = resp_r;
   assign bank_out       = bank_r;
   assign bus_error_out  = berr_r;
   assign trap_reset_out = trap_r;

endmodule // brf_core

`default_nettype wire

// ==== hw/brf_pkg.sv ====
// Constants, enumerations and carrier structs for the banked register file RAM.
// Assumes a single 25 MHz clock shared with the CPU core that issues requests.
`default_nettype none

package brf_pkg;

   // Clock and the hold time of the address-trap reset.
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TRAP_HOLD_NS  = 1000;
   localparam int unsigned TRAP_HOLD_CYC = (TRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRAP_CNT_W    = 5;

   // Data address map.
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned IDX_W       = 9;
   localparam int unsigned RAM_BYTES   = 512;
   localparam logic [15:0] RAM_BASE    = 16'h0040;
   localparam logic [15:0] RAM_LAST    = 16'h023F;
   localparam logic [15:0] DIRECT_LAST = 16'h00FF;
   localparam logic [15:0] BANK_LAST   = 16'h00BF;

   // Bank layout: sixteen banks of eight bytes, pairs little-endian.
   localparam int unsigned BANK_W     = 4;
   localparam logic [2:0]  REG_ACC    = 3'h0;
   localparam logic [2:0]  REG_ACC_HI = 3'h1;
   localparam logic [2:0]  REG_OFFSET = 3'h2;
   localparam logic [1:0]  PAIR_WIDE  = 2'h0;
   localparam logic [1:0]  PAIR_COUNT = 2'h1;
   localparam logic [1:0]  PAIR_SEC   = 2'h2;
   localparam logic [1:0]  PAIR_PRI   = 2'h3;

   // Status word layout as saved on the stack.
   localparam int unsigned PSW_BANK_LSB  = 0;
   localparam int unsigned PSW_FLAG_LSB  = 4;
   localparam logic [3:0]  BANK_RESET    = 4'h0;

   typedef enum logic [3:0] {
      BRF_CMD_NONE, BRF_CMD_MEM_RD, BRF_CMD_MEM_WR, BRF_CMD_REG_RD, BRF_CMD_REG_WR,
      BRF_CMD_PAIR_RD, BRF_CMD_PAIR_WR, BRF_CMD_MEM_OP, BRF_CMD_BANK_WR,
      BRF_CMD_IRQ_ENTRY, BRF_CMD_IRQ_RETURN
   } brf_cmd_t;

   typedef enum logic [2:0] {
      BRF_MODE_DIRECT, BRF_MODE_SHORT, BRF_MODE_PTR_PRI, BRF_MODE_PTR_SEC,
      BRF_MODE_INDEX, BRF_MODE_BASE, BRF_MODE_POST_INC, BRF_MODE_PRE_DEC
   } brf_mode_t;

   typedef enum logic [2:0] {
      BRF_OP_MOVE, BRF_OP_ADD, BRF_OP_SUB, BRF_OP_AND, BRF_OP_OR, BRF_OP_XOR
   } brf_aluop_t;

   typedef struct packed {
      brf_cmd_t   cmd;
      brf_mode_t  mode;
      brf_aluop_t aluop;
      logic [2:0] sel;
      logic [15:0] addr;
      logic [7:0]  disp;
      logic [15:0] wdata;
      logic [3:0]  flags;
   } brf_req_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] data;
      logic [15:0] ea;
   } brf_resp_t;

endpackage

`default_nettype wire

// ==== tb/brf_checker.sv ====
// Port-level timing checks for the banked register file RAM.
// Assumes it is bound to brf_core and sees nothing but that module's ports.
`timescale 1ns/100ps
`default_nettype none
module brf_checker
   import brf_pkg::*;
(
   input wire logic              clk_in,         // CPU clock.
   input wire logic              arst_n_in,      // Reset, active low.
   input wire brf_req_t          req_in,         // CPU request.
   input wire logic              fetch_valid_in, // Fetch strobe.
   input wire logic [15:0]       fetch_addr_in,  // Fetch address.
   input wire logic              rst_pin_in,     // Resolved reset pin level.
   input wire logic              rst_pin_out,    // Reset pin drive value.
   input wire logic              rst_pin_oe_out, // Reset pin enable.
   input wire brf_resp_t         resp_out,       // Registered answer.
   input wire logic [BANK_W-1:0] bank_out,       // Current bank.
   input wire logic              bus_error_out,  // Bus error pulse.
   input wire logic              trap_reset_out  // Trap in progress.
);
   ////////////////////////////////////////////////////////////////////////////////
   logic taken;
   logic ram_fetch;
   // A request only counts when the device is not held in any reset.
   assign taken = req_in.cmd != BRF_CMD_NONE && !trap_reset_out && rst_pin_in;
   assign ram_fetch = fetch_valid_in && fetch_addr_in >= RAM_BASE && fetch_addr_in <= RAM_LAST;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   ////////////////////////////////////////////////////////////////////////////////
   // Every check ties an output to its cause with the exact cycle count.
   answer_latency_a: assert property (taken |=> resp_out.valid)
      else $error("taken request got no answer");
   no_spurious_a: assert property (!taken |=> !resp_out.valid)
      else $error("answer without a taken request");
   range_err_a: assert property (taken && req_in.cmd == BRF_CMD_MEM_RD && req_in.mode == BRF_MODE_DIRECT
      && (req_in.addr < RAM_BASE || req_in.addr > RAM_LAST) |=> resp_out.err && resp_out.data == 16'h0000)
      else $error("unmapped read not flagged");
   trap_start_a: assert property (ram_fetch && !trap_reset_out |=> bus_error_out && trap_reset_out)
      else $error("data fetch did not trap");
   code_fetch_a: assert property (!ram_fetch && !trap_reset_out |=> !trap_reset_out)
      else $error("trap without a data fetch");
   error_pulse_a: assert property (bus_error_out |=> !bus_error_out)
      else $error("bus error longer than one cycle");
   trap_length_a: assert property ($rose(trap_reset_out) |-> trap_reset_out[*8] ##17 trap_reset_out
      ##1 !trap_reset_out)
      else $error("trap length wrong");
   pin_low_a: assert property (rst_pin_oe_out == trap_reset_out && !rst_pin_out)
      else $error("reset pin not pulled during trap");
   bank_held_a: assert property (trap_reset_out |-> bank_out == BANK_RESET)
      else $error("bank not cleared during trap");
   // A trap starting at the same edge overrides the write with bank zero.
   bank_write_a: assert property (taken && req_in.cmd == BRF_CMD_BANK_WR && !ram_fetch
      |=> bank_out == $past(req_in.wdata[3:0]))
      else $error("bank write not applied");
endmodule // brf_checker
bind brf_core brf_checker brf_checker_i (.clk_in, .arst_n_in, .req_in, .fetch_valid_in, .fetch_addr_in,
   .rst_pin_in, .rst_pin_out, .rst_pin_oe_out, .resp_out, .bank_out, .bus_error_out, .trap_reset_out);
`default_nettype wire

// ==== tb/brf_pin_model.sv ====
// Model of the board side of the open-drain reset pin.
// Assumes a pull-up on the pin and an external party that may hold it low.
`timescale 1ns/100ps
`default_nettype none
module brf_pin_model (
   input  wire logic rst_pin_out,    // Device drive value.
   input  wire logic rst_pin_oe_out, // Device drive enable.
   input  wire logic ext_low_in,     // External party pulls low.
   output logic      pin_out         // Resolved pin level.
);
   // The pull-up wins only when nobody pulls, so a released pin never shows a stale level.
   assign pin_out = (rst_pin_oe_out ? rst_pin_out : 1'b1) & !ext_low_in;
endmodule // brf_pin_model
`default_nettype wire

// ==== tb/banked_register_file_ram_test.sv ====
// Self-checking bench for the banked register file RAM.
// Assumes brf_core, its checker bind and the reset pin model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module banked_register_file_ram_test
   import brf_pkg::*;
;
   logic              clk_in, arst_n_in, fetch_valid_in, rst_pin_in, rst_pin_out, rst_pin_oe_out;
   logic              bus_error_out, trap_reset_out, ext_low, g_live;
   logic [15:0]       fetch_addr_in, a;
   logic [BANK_W-1:0] bank_out, g_bank;
   logic [7:0]        m [0:511];
   logic [7:0]        g_disp, e;
   logic [31:0]       seed;
   brf_aluop_t        g_alu;
   brf_req_t          req_in;
   brf_resp_t         resp_out, rs;
   int                errors, comparisons;

   brf_core brf_core_i (.clk_in, .arst_n_in, .req_in, .fetch_valid_in, .fetch_addr_in, .rst_pin_in,
      .rst_pin_out, .rst_pin_oe_out, .resp_out, .bank_out, .bus_error_out, .trap_reset_out);
   brf_pin_model brf_pin_model_i (.rst_pin_out, .rst_pin_oe_out, .ext_low_in(ext_low), .pin_out(rst_pin_in));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers: random source, expected results, and the single compare point.
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] alu(input brf_aluop_t k, input logic [7:0] x, y);
      case (k)
         BRF_OP_ADD: return x + y;
         BRF_OP_SUB: return x - y;
         BRF_OP_AND: return x & y;
         BRF_OP_OR:  return x | y;
         BRF_OP_XOR: return x ^ y;
         default:    return y;
      endcase
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks: each starts at a falling edge and ends one falling edge later.
   task automatic op(input brf_cmd_t c, input brf_mode_t md, input logic [2:0] s, input logic [15:0] ad, w);
      req_in = '{cmd:c, mode:md, aluop:g_alu, sel:s, addr:ad, disp:g_disp, wdata:w, flags:w[3:0]};
      @(negedge clk_in);
      rs = resp_out;
      chk("valid", 16'(rs.valid), 16'(g_live));
   endtask
   task automatic mw(input logic [15:0] ad, input logic [7:0] d);
      op(BRF_CMD_MEM_WR, BRF_MODE_DIRECT, 3'h0, ad, {8'h00, d});
      m[ad - RAM_BASE] = d;
   endtask
   task automatic mr(input logic [15:0] ad);
      logic ok;
      ok = ad >= RAM_BASE && ad <= RAM_LAST;
      op(BRF_CMD_MEM_RD, BRF_MODE_DIRECT, 3'h0, ad, 16'h0000);
      chk("err", 16'(rs.err), 16'(!ok));
      chk("rdata", rs.data, ok ? {8'h00, m[ad - RAM_BASE]} : 16'h0000);
   endtask
   task automatic mp(input brf_mode_t md, input logic [15:0] ad);
      op(BRF_CMD_MEM_RD, md, 3'h0, 16'h0000, 16'h0000);
      chk("ea", rs.ea, ad);
      chk("pdata", rs.data, {8'h00, m[ad - RAM_BASE]});
   endtask
   task automatic bw(input logic [3:0] n);
      op(BRF_CMD_BANK_WR, BRF_MODE_DIRECT, 3'h0, {12'h000, n}, {12'h000, n});
      if (g_live) g_bank = n;
      chk("bank", 16'(bank_out), g_live ? 16'(n) : 16'h0000);
   endtask
   task automatic pw(input logic [1:0] p, input logic [15:0] v);
      op(BRF_CMD_PAIR_WR, BRF_MODE_DIRECT, {1'b0, p}, 16'h0000, v);
      {m[8 * g_bank + 2 * p + 1], m[8 * g_bank + 2 * p]} = v;
   endtask
   task automatic ft(input logic [15:0] ad, input logic x);
      fetch_valid_in = 1'b1;
      fetch_addr_in = ad;
      @(negedge clk_in);
      fetch_valid_in = 1'b0;
      chk("trap", 16'(trap_reset_out), 16'(x));
      chk("buserr", 16'(bus_error_out), 16'(x));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and main sequence.
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      // The tests need about 1,100 cycles; the limit allows more than ten times that.
      #(20000 * 40);
      errors++;
      tally_and_finish();
   end
   initial begin
      {arst_n_in, fetch_valid_in, ext_low, g_disp, g_bank} = '0;
      {req_in, fetch_addr_in, errors, comparisons} = '0;
      g_alu = BRF_OP_MOVE;
      g_live = 1'b1;
      seed = 32'hE5E0;
      repeat (3) @(negedge clk_in);
      arst_n_in = 1'b1;
      chk("bank", 16'(bank_out), 16'h0000);
      for (int i = 8; i < RAM_BYTES; i++) mw(RAM_BASE + 16'(i), rnd());
      for (int n = 0; n < 16; n++) begin
         bw(4'(n));
         for (int r = 0; r < 8; r++) begin
            e = rnd();
            op(BRF_CMD_REG_WR, BRF_MODE_DIRECT, 3'(r), 16'h0000, {8'h00, e});
            m[8 * n + r] = e;
         end
         for (int r = 0; r < 8; r++) begin
            op(BRF_CMD_REG_RD, BRF_MODE_DIRECT, 3'(r), 16'h0000, 16'h0000);
            chk("reg", rs.data, {8'h00, m[8 * n + r]});
         end
         for (int p = 0; p < 4; p++) begin
            op(BRF_CMD_PAIR_RD, BRF_MODE_DIRECT, 3'(p), 16'h0000, 16'h0000);
            chk("pair", rs.data, {m[8 * n + 2 * p + 1], m[8 * n + 2 * p]});
         end
      end
      for (int i = 0; i < 128; i++) mr(RAM_BASE + 16'(i));
      for (int i = 0; i < 40; i++) begin
         a = RAM_BASE + 16'(rnd()) + 16'(rnd() & 8'h01) * 16'h0100;
         mw(a, rnd());
         mr(a);
      end
      mr(16'h003F);
      mr(16'h0240);
      op(BRF_CMD_MEM_RD, BRF_MODE_SHORT, 3'h0, 16'h00FF, 16'h0000);
      chk("short", rs.data, {8'h00, m[16'h00FF - RAM_BASE]});
      pw(2'h3, 16'h0150);
      pw(2'h1, 16'h0033);
      pw(2'h2, 16'h0200);
      mp(BRF_MODE_PTR_PRI, 16'h0150);
      mp(BRF_MODE_PTR_SEC, 16'h0200);
      g_disp = 8'hF0;
      mp(BRF_MODE_INDEX, 16'h0140);
      mp(BRF_MODE_BASE, 16'h0183);
      mp(BRF_MODE_POST_INC, 16'h0150);
      mp(BRF_MODE_PTR_PRI, 16'h0151);
      mp(BRF_MODE_PRE_DEC, 16'h0150);
      for (int k = 0; k < 6; k++) begin
         g_alu = brf_aluop_t'(k);
         e = alu(g_alu, m[16'h0150 - RAM_BASE], m[16'h0200 - RAM_BASE]);
         op(BRF_CMD_MEM_OP, BRF_MODE_PTR_PRI, 3'h0, 16'h0000, 16'h0000);
         m[16'h0150 - RAM_BASE] = e;
         chk("memop", 16'(rs.data[7:0]), 16'(e));
         mr(16'h0150);
      end
      bw(4'h5);
      op(BRF_CMD_IRQ_ENTRY, BRF_MODE_DIRECT, 3'h0, 16'h0200, 16'h000A);
      m[16'h0200 - RAM_BASE] = 8'hA5;
      mr(16'h0200);
      bw(4'h0);
      op(BRF_CMD_IRQ_RETURN, BRF_MODE_DIRECT, 3'h0, 16'h0200, 16'h0000);
      chk("reti", 16'(bank_out), 16'h0005);
      req_in = '0;
      ft(16'h8000, 1'b0);
      ft(16'h0100, 1'b1);
      chk("pin", {14'h0000, rst_pin_oe_out, rst_pin_in}, 16'h0002);
      e = m[16'h0100 - RAM_BASE];
      g_live = 1'b0;
      mw(16'h0100, ~e);
      m[16'h0100 - RAM_BASE] = e;
      for (int i = 0; i < 40 && trap_reset_out; i++) @(negedge clk_in);
      g_live = 1'b1;
      op(BRF_CMD_MEM_RD, BRF_MODE_DIRECT, 3'h0, 16'h0100, 16'h0000);
      chk("refused", rs.data, {8'h00, e});
      ext_low = 1'b1;
      g_live = 1'b0;
      bw(4'h7);
      ext_low = 1'b0;
      g_live = 1'b1;
      bw(4'h9);
      req_in = '0;
      arst_n_in = 1'b0;
      @(negedge clk_in);
      arst_n_in = 1'b1;
      chk("bank", 16'(bank_out), 16'h0000);
      mr(16'h0150);
      chk("bank", 16'(bank_out), 16'h0000);
      tally_and_finish();
   end
endmodule // banked_register_file_ram_test
`default_nettype wire
